// ==== design/sgs_serdes_top.sv ====
// Gigabit serializer transmit path with a simple receive deserializer
`timescale 1ns/1ps
`include "sgs_regs.svh"
// Functional notes
// - Width select low picks ten-bit mode, high picks five-bit double-edge mode.
// - Ten-bit mode: whole word captured on reference clock rising edge.
// - Bit clock is ten times the reference clock; one word per period.
// - Serial output sends bit 0 first, bit 9 last.
// - Double-edge mode: low five lines sampled on both reference edges.
// - Double-edge: bits 0-4 at rising edge, bits 5-9 at next falling edge.
// - Two halves are joined into one word before serializing.
// - During reset byte clocks, receive data and serial pair float.
// - Incoming serial stream retimed, deserialized into 10-bit bytes.
// - Ten-bit mode: load to bit 9 sent takes 19 to 20 bit times.
// - Double-edge mode: load to bit 9 sent takes 29 to 30 bit times.
module sgs_serdes_top
  import sgs_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      sys_rst_i,
  input  wire logic      reference_clock_in_i,
  input  wire logic      interface_width_select_i,
  input  wire sgs_word_t transmit_parallel_bits_i,
  input  wire logic      rx_serial_positive_i,
  input  wire logic      rx_serial_negative_i,
  output logic           serial_out_positive_o,
  output logic           serial_out_negative_o,
  output logic           serial_out_oe_n_o,
  output sgs_word_t      receive_parallel_bits_o,
  output logic           receive_byte_clock_a_o,
  output logic           receive_byte_clock_b_o,
  output logic           receive_oe_n_o
);

  localparam sgs_tx_state_t TX_RST = '{
    ref_s1: 1'b0, ref_s2: 1'b0, ref_d: 1'b0,
    mode_s1: 1'b0, mode_s2: 1'b0,
    td_s1: '0, td_s2: '0,
    rx_s1: 1'b0, rx_s2: 1'b0,
    per_cnt: '0, period: '1, acc: '0,
    bit_idx: `SGS_LAST_BIT,
    low_half: '0, hold: '0, hold_v: 1'b0,
    stage: '0, stage_v: 1'b0,
    shift: '0, tx_p: 1'b0, tx_n: 1'b1, tx_oe_n: 1'b1
  };

  sgs_tx_state_t r_r;
  sgs_tx_state_t r_nxt;
  logic          ref_rise;
  logic          ref_fall;
  logic          ddr_mode;
  logic          bit_stb;
  logic [`SGS_PER_W:0] acc_sum;
  sgs_word_t     load_word;
  logic          load_v;

  // Edge and mode decode from the synchronised pins
  assign ref_rise = r_r.ref_s2 & ~r_r.ref_d;
  assign ref_fall = ~r_r.ref_s2 & r_r.ref_d;
  assign ddr_mode = (r_r.mode_s2 != `SGS_TBI_MODE);
  assign acc_sum  = r_r.acc + (`SGS_PER_W+1)'(`SGS_BIT_MULT);

  // Double-edge words pass one extra stage to meet their longer latency
  assign load_word = ddr_mode ? r_r.stage : r_r.hold;
  assign load_v    = ddr_mode ? r_r.stage_v : r_r.hold_v;

  always_comb begin
    r_nxt   = r_r;
    bit_stb = 1'b0;

    // Every pin passes two flip-flops; the first is read only here
    r_nxt.ref_s1  = reference_clock_in_i;
    r_nxt.ref_s2  = r_r.ref_s1;
    r_nxt.ref_d   = r_r.ref_s2;
    r_nxt.mode_s1 = interface_width_select_i;
    r_nxt.mode_s2 = r_r.mode_s1;
    r_nxt.td_s1   = transmit_parallel_bits_i;
    r_nxt.td_s2   = r_r.td_s1;
    r_nxt.rx_s1   = rx_serial_positive_i & ~rx_serial_negative_i;
    r_nxt.rx_s2   = r_r.rx_s1;

    // Reference period in system clocks, measured rise to rise
    if (ref_rise) begin
      r_nxt.period  = r_r.per_cnt + `SGS_PER_W'(1);
      r_nxt.per_cnt = '0;
    end else if (r_r.per_cnt != '1) begin
      r_nxt.per_cnt = r_r.per_cnt + `SGS_PER_W'(1);
    end

    // Fractional divider: ten bit strobes per reference period.
    // Bit 0 is pinned to the rising edge so the word rate tracks it.
    if (ref_rise) begin
      bit_stb       = 1'b1;
      r_nxt.acc     = '0;
      r_nxt.bit_idx = 4'h0;
    end else if (r_r.bit_idx != `SGS_LAST_BIT) begin
      if (acc_sum >= {1'b0, r_r.period}) begin
        bit_stb       = 1'b1;
        r_nxt.acc     = acc_sum - {1'b0, r_r.period};
        r_nxt.bit_idx = r_r.bit_idx + 4'h1;
      end else begin
        r_nxt.acc = acc_sum;
      end
    end

    // Parallel capture on reference edges
    if (ref_rise) begin
      if (ddr_mode) begin
        r_nxt.low_half = r_r.td_s2[`SGS_HALF_W-1:0];
        r_nxt.stage    = r_r.hold;
        r_nxt.stage_v  = r_r.hold_v;
      end else begin
        r_nxt.hold   = r_r.td_s2;
        r_nxt.hold_v = 1'b1;
      end
    end else if (ref_fall && ddr_mode) begin
      // Upper lines are never read in this mode
      r_nxt.hold   = {r_r.td_s2[`SGS_HALF_W-1:0], r_r.low_half};
      r_nxt.hold_v = 1'b1;
    end

    // Serializer: load on rising edge, shift right on each bit strobe
    if (ref_rise && load_v) begin
      r_nxt.shift   = load_word;
      r_nxt.tx_p    = load_word[0];
      r_nxt.tx_n    = ~load_word[0];
      r_nxt.tx_oe_n = 1'b0;
    end else if (bit_stb) begin
      r_nxt.shift = {1'b0, r_r.shift[`SGS_WORD_W-1:1]};
      r_nxt.tx_p  = r_r.shift[1];
      r_nxt.tx_n  = ~r_r.shift[1];
    end
  end

  // Single register for all transmit state; outputs float in reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      r_r <= TX_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Receive side reuses the reference-derived bit strobe for retiming
  sgs_rx_deser u_rx (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .bit_stb_i (bit_stb),
    .rx_bit_i  (r_r.rx_s2),
    .rx_data_o (receive_parallel_bits_o),
    .rbc_a_o   (receive_byte_clock_a_o),
    .rbc_b_o   (receive_byte_clock_b_o),
    .rx_oe_n_o (receive_oe_n_o)
  );

  // Each leg has its own flop so no inverter skews the pair at the pin
  assign serial_out_positive_o = r_r.tx_p;
  assign serial_out_negative_o = r_r.tx_n;
  assign serial_out_oe_n_o     = r_r.tx_oe_n;

endmodule : sgs_serdes_top

// ==== design/sgs_regs.svh ====
// Constants for the gigabit serializer transmit path
`ifndef SGS_REGS_SVH
`define SGS_REGS_SVH
`define SGS_WORD_W   10     // Encoded word width
`define SGS_HALF_W   5      // Double-edge half width
`define SGS_BIT_MULT 10     // Bit clock to reference clock ratio
`define SGS_LAST_BIT 4'h9   // Index of the last bit of a word
`define SGS_RX_MID   4'h4   // Bit index where receive byte clock rises
`define SGS_PER_W    16     // Width of the reference period counter
`define SGS_TBI_MODE 1'b0   // Width select level for ten-bit mode
`endif

// ==== design/sgs_pkg.sv ====
// Types shared by the serializer and the receive deserializer
package sgs_pkg;
`include "sgs_regs.svh"

  typedef logic [`SGS_WORD_W-1:0] sgs_word_t;

  // Transmit side state
  typedef struct packed {
    logic                  ref_s1;
    logic                  ref_s2;
    logic                  ref_d;
    logic                  mode_s1;
    logic                  mode_s2;
    sgs_word_t             td_s1;
    sgs_word_t             td_s2;
    logic                  rx_s1;
    logic                  rx_s2;
    logic [`SGS_PER_W-1:0] per_cnt;
    logic [`SGS_PER_W-1:0] period;
    logic [`SGS_PER_W:0]   acc;
    logic [3:0]            bit_idx;
    logic [`SGS_HALF_W-1:0] low_half;
    sgs_word_t             hold;
    logic                  hold_v;
    sgs_word_t             stage;
    logic                  stage_v;
    sgs_word_t             shift;
    logic                  tx_p;
    logic                  tx_n;
    logic                  tx_oe_n;
  } sgs_tx_state_t;

  // Receive side state
  typedef struct packed {
    sgs_word_t  shift;
    logic [3:0] cnt;
    sgs_word_t  data;
    logic       clk_a;
    logic       clk_b;
    logic       oe_n;
  } sgs_rx_state_t;

endpackage : sgs_pkg

// ==== design/sgs_rx_deser.sv ====
// Receive deserializer: retimed serial bits into 10-bit bytes
`timescale 1ns/1ps
`include "sgs_regs.svh"
module sgs_rx_deser
  import sgs_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      sys_rst_i,
  input  wire logic      bit_stb_i,
  input  wire logic      rx_bit_i,
  output sgs_word_t      rx_data_o,
  output logic           rbc_a_o,
  output logic           rbc_b_o,
  output logic           rx_oe_n_o
);

  sgs_rx_state_t r_r;
  sgs_rx_state_t r_nxt;

  // Bits arrive bit 0 first, so they enter at the top and move down
  always_comb begin
    r_nxt = r_r;
    r_nxt.oe_n = 1'b0;
    r_nxt.clk_b = 1'b0;  // Second byte clock idles in full-rate mode
    if (bit_stb_i) begin
      r_nxt.shift = {rx_bit_i, r_r.shift[`SGS_WORD_W-1:1]};
      if (r_r.cnt == `SGS_LAST_BIT) begin
        r_nxt.cnt   = 4'h0;
        r_nxt.data  = {rx_bit_i, r_r.shift[`SGS_WORD_W-1:1]};
        r_nxt.clk_a = 1'b0;  // Data changes while clock is low
      end else begin
        r_nxt.cnt = r_r.cnt + 4'h1;
        if (r_r.cnt == `SGS_RX_MID) begin
          r_nxt.clk_a = 1'b1;  // Rising edge mid-byte, data settled
        end
      end
    end
  end

  // Register; outputs float until reset is released
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      r_r <= '{shift: '0, cnt: 4'h0, data: '0, clk_a: 1'b0, clk_b: 1'b0, oe_n: 1'b1};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rx_data_o = r_r.data;
  assign rbc_a_o   = r_r.clk_a;
  assign rbc_b_o   = r_r.clk_b;
  assign rx_oe_n_o = r_r.oe_n;

endmodule : sgs_rx_deser

// ==== dv/sgs_serdes_top_properties.sv ====
// Port checker for the serializer top
`timescale 1ns/1ps
module sgs_serdes_chk
  import sgs_pkg::*;
(
  input wire logic      mclk_i,
  input wire logic      sys_rst_i,
  input wire logic      reference_clock_in_i,
  input wire logic      interface_width_select_i,
  input wire sgs_word_t transmit_parallel_bits_i,
  input wire logic      rx_serial_positive_i,
  input wire logic      rx_serial_negative_i,
  input wire logic      serial_out_positive_o,
  input wire logic      serial_out_negative_o,
  input wire logic      serial_out_oe_n_o,
  input wire sgs_word_t receive_parallel_bits_o,
  input wire logic      receive_byte_clock_a_o,
  input wire logic      receive_byte_clock_b_o,
  input wire logic      receive_oe_n_o
);
  default clocking @(posedge mclk_i); endclocking
  // Bit time is a tenth of a 40-clock reference period, so at least 3 clocks
  AST_PAIR: assert property (disable iff (sys_rst_i)
    !serial_out_oe_n_o |-> serial_out_negative_o == !serial_out_positive_o)
    else $error("serial pair skew");
  AST_FLOAT: assert property (sys_rst_i |=> serial_out_oe_n_o && receive_oe_n_o)
    else $error("outputs driven in reset");
  AST_RX_ON: assert property (disable iff (sys_rst_i) $fell(sys_rst_i) |=> !receive_oe_n_o)
    else $error("receive outputs not enabled");
  AST_RBC_B: assert property (disable iff (sys_rst_i) !receive_byte_clock_b_o)
    else $error("byte clock b not low");
  AST_RX_EDGE: assert property (disable iff (sys_rst_i)
    $changed(receive_parallel_bits_o) |-> !receive_byte_clock_a_o)
    else $error("data change with clock a high");
  AST_RX_HOLD: assert property (disable iff (sys_rst_i)
    $changed(receive_parallel_bits_o) |=> $stable(receive_parallel_bits_o)[*8])
    else $error("receive byte too short");
  AST_RBC_MID: assert property (disable iff (sys_rst_i)
    $rose(receive_byte_clock_a_o) |-> $stable(receive_parallel_bits_o))
    else $error("clock a rise on data change");
  AST_BIT: assert property (disable iff (sys_rst_i) !serial_out_oe_n_o
    && $changed(serial_out_positive_o) |=> $stable(serial_out_positive_o)[*2])
    else $error("serial bit too short");
  COV_TX: cover property ($fell(serial_out_oe_n_o));
  COV_DDR: cover property (interface_width_select_i && !serial_out_oe_n_o);
  COV_RBC: cover property ($rose(receive_byte_clock_a_o));
endmodule : sgs_serdes_chk

// ==== dv/sgs_ctrl_model.sv ====
// Protocol controller model: reference clock and parallel words
`timescale 1ns/1ps
module sgs_ctrl_model
  import sgs_pkg::*;
#(
  parameter int PER = 40
)
(
  input  wire logic      mclk_i,
  input  wire logic      ddr_i,
  input  wire sgs_word_t word_i,
  output logic           ref_o,
  output sgs_word_t      td_o,
  output logic [7:0]     phase_o
);
  logic [7:0] nx;
  sgs_word_t  cur;
  initial begin
    ref_o = 1'b0;
    td_o = '0;
    phase_o = 8'h00;
    cur = '0;
  end
  // Data moves mid-phase so it is settled at both clock edges
  always @(posedge mclk_i) begin
    nx = (phase_o == 8'(PER - 1)) ? 8'h00 : phase_o + 8'h01;
    phase_o <= nx;
    ref_o <= (nx < 8'(PER / 2));
    if (nx == 8'(PER * 3 / 4)) begin
      cur <= word_i;
      td_o <= ddr_i ? {~word_i[4:0], word_i[4:0]} : word_i;
    end else if (ddr_i && nx == 8'(PER / 4)) begin
      td_o <= {~cur[4:0], cur[9:5]};
    end
  end
endmodule : sgs_ctrl_model

// ==== dv/testbench.sv ====
// Self-checking bench for the serializer top
`timescale 1ns/1ps
module testbench;
  import sgs_pkg::*;
  logic      mclk_i = 1'b0;
  logic      sys_rst_i = 1'b1;
  logic      interface_width_select_i = 1'b0;
  logic      reference_clock_in_i, serial_out_positive_o, serial_out_negative_o;
  logic      serial_out_oe_n_o, receive_byte_clock_a_o, receive_byte_clock_b_o;
  logic      receive_oe_n_o, rx_serial_positive_i, rx_serial_negative_i, fixed;
  sgs_word_t transmit_parallel_bits_i, receive_parallel_bits_o, word, w, sh;
  sgs_word_t hist[$];
  logic [7:0] phase;
  integer    seed = 84;
  int        n_errors = 0, cmp_count = 0, settle = 0, nw = 0;
  always #10 mclk_i = ~mclk_i;
  // Loop back; a floating pair shows a changing pattern
  assign rx_serial_positive_i = serial_out_oe_n_o ? phase[0] : serial_out_positive_o;
  assign rx_serial_negative_i = serial_out_oe_n_o ? phase[1] : serial_out_negative_o;
  sgs_serdes_top dut (.*);
  sgs_ctrl_model #(.PER(40)) u_ctrl (.mclk_i(mclk_i), .ddr_i(interface_width_select_i),
    .word_i(word), .ref_o(reference_clock_in_i), .td_o(transmit_parallel_bits_i),
    .phase_o(phase));
  task automatic chk_w(input string nm, input sgs_word_t e, input sgs_word_t g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk_w
  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_w(nm, {9'h000, e}, {9'h000, g});
  endtask : chk_b
  task automatic report_and_stop;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  function automatic logic is_rot(input sgs_word_t a, input sgs_word_t b);
    is_rot = 1'b0;
    for (int i = 0; i < 10; i++)
      if (((a >> i) | (a << (10 - i))) == b) is_rot = 1'b1;
  endfunction : is_rot
  // Mid-bit sampling: bit k at phase 5+4k, bit 9 falls in the next period
  always @(posedge mclk_i) begin
    if (phase[1:0] == 2'h1) begin
      w = {serial_out_positive_o, sh[9:1]};
      sh <= w;
      if (phase == 8'h01 && settle > 4) begin
        chk_w("tx_word", hist[$ - (interface_width_select_i ? 3 : 2)], w);
        nw++;
      end
    end
    if (phase == 8'h01) settle++;
    if (phase == 8'h1d) begin
      hist.push_back(word);
      word <= fixed ? word : 10'($random(seed));
    end
  end
  initial begin
    word = '0;
    sh = '0;
    fixed = 1'b0;
    for (int m = 0; m < 2; m++) begin
      interface_width_select_i <= m[0];
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk_b("tx_oe_n", 1'b1, serial_out_oe_n_o);
      chk_b("rx_oe_n", 1'b1, receive_oe_n_o);
      sys_rst_i <= 1'b0;
      settle = 0;
      repeat (1600) @(posedge mclk_i);
    end
    fixed <= 1'b1;
    repeat (320) @(posedge mclk_i);
    chk_b("rx_rot", 1'b1, is_rot(word, receive_parallel_bits_o));
    chk_b("words", 1'b1, nw > 60);
    report_and_stop();
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule : testbench
bind sgs_serdes_top sgs_serdes_chk u_chk (.*);
